// File: verilog/rps_top.sv
// Output pin select registers on AHB-Lite with the per-pin routing
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module rps_top #(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter int FUNCS = rps_pkg::NUM_FUNCS
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    // Peripheral outputs, indexed by function number
    input wire logic [FUNCS-1:0] periph_data,
    input wire logic [FUNCS-1:0] periph_oe,
    // Ordinary port function of pins six to fifteen
    input wire logic [rps_pkg::NUM_PINS-1:0] port_data,
    input wire logic [rps_pkg::NUM_PINS-1:0] port_oe,
    // Pins six to fifteen, bit 0 is pin six
    output logic [rps_pkg::NUM_PINS-1:0] pin_out,
    output logic [rps_pkg::NUM_PINS-1:0] pin_oe,
    output logic [rps_pkg::NUM_PINS-1:0] pin_remapped
);

    if (FUNCS > (1 << rps_pkg::FIELD_W) || FUNCS < 2) begin : g_chk
        $error("rps_top: FUNCS does not fit the select field");
    end

    rps_pkg::rps_aph_t aph_ff;
    rps_pkg::rps_aph_t nxt_aph;
    rps_pkg::rps_pair_t [rps_pkg::NUM_PAIRS-1:0] sel_ff;
    rps_pkg::rps_pair_t [rps_pkg::NUM_PAIRS-1:0] nxt_sel;
    logic hreadyout_ff;
    logic [1:0] hresp_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_rdata;
    logic [rps_pkg::OFF_W-1:0] off;
    logic take;

    // Address phase decode
    always_comb begin
        off = haddr[rps_pkg::OFF_W-1:0];
        take = hsel && hready && (htrans == rps_pkg::HTRANS_NONSEQ
            || htrans == 2'h3);
        nxt_aph.valid = take;
        nxt_aph.write = hwrite;
        nxt_aph.idx = off[4:2];
        nxt_aph.hit = 1'b0;
        case (off)
            rps_pkg::OFF_SEL_6_7,
            rps_pkg::OFF_SEL_8_9,
            rps_pkg::OFF_SEL_10_11,
            rps_pkg::OFF_SEL_12_13,
            rps_pkg::OFF_SEL_14_15: begin
                nxt_aph.hit = 1'b1;
            end
            default: begin
                nxt_aph.hit = 1'b0;
            end
        endcase
        case (hsize)
            rps_pkg::HSIZE_BYTE: begin
                nxt_aph.strb = 4'h1 << haddr[1:0];
            end
            rps_pkg::HSIZE_HALF: begin
                nxt_aph.strb = haddr[1] ? 4'hC : 4'h3;
            end
            default: begin
                nxt_aph.strb = 4'hF;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_ff <= '0;
        end else if (hready) begin
            aph_ff <= nxt_aph;
        end
    end

    // Data phase write into the select fields
    always_comb begin
        nxt_sel = sel_ff;
        if (aph_ff.valid && aph_ff.write && aph_ff.hit) begin
            if (aph_ff.strb[1]) begin
                nxt_sel[aph_ff.idx].hi =
                    hwdata[rps_pkg::HI_MSB:rps_pkg::HI_LSB];
            end
            if (aph_ff.strb[0]) begin
                nxt_sel[aph_ff.idx].lo =
                    hwdata[rps_pkg::LO_MSB:rps_pkg::LO_LSB];
            end
        end
        if (SMALL_PACKAGE) begin
            nxt_sel[rps_pkg::PIN15_PAIR].hi = rps_pkg::FUNC_NONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_ff <= {rps_pkg::NUM_PAIRS{
                rps_pkg::REG_RESET[rps_pkg::HI_MSB:rps_pkg::HI_LSB],
                rps_pkg::REG_RESET[rps_pkg::LO_MSB:rps_pkg::LO_LSB]}};
        end else begin
            sel_ff <= nxt_sel;
        end
    end

    // Read data; built from the next field values so a read right after
    // a write to the same register sees the new value
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (take && !hwrite && nxt_aph.hit) begin
            nxt_rdata[rps_pkg::HI_MSB:rps_pkg::HI_LSB] =
                nxt_sel[nxt_aph.idx].hi;
            nxt_rdata[rps_pkg::LO_MSB:rps_pkg::LO_LSB] =
                nxt_sel[nxt_aph.idx].lo;
            nxt_rdata[15:14] = 2'h0;
            nxt_rdata[7:6] = 2'h0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (hready) begin
            hrdata_ff <= nxt_rdata;
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= rps_pkg::HRESP_OKAY;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= rps_pkg::HRESP_OKAY;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;

    // Per-pin routing; even pin from the low field, odd pin from the high
    for (genvar p = 0; p < rps_pkg::NUM_PINS; p++) begin : g_pin
        logic [rps_pkg::FIELD_W-1:0] sel_p;
        if (p % 2 == 0) begin : g_even
            assign sel_p = sel_ff[p/2].lo;
        end else begin : g_odd
            assign sel_p = sel_ff[p/2].hi;
        end
        rps_pin_mux #(
            .FUNCS(FUNCS),
            .SEL_W(rps_pkg::FIELD_W)
        ) u_mux (
            .hclk(hclk),
            .hresetn(hresetn),
            .sel(sel_p),
            .periph_data(periph_data),
            .periph_oe(periph_oe),
            .port_data(port_data[p]),
            .port_oe(port_oe[p]),
            .pin_out_ff(pin_out[p]),
            .pin_oe_ff(pin_oe[p]),
            .remapped_ff(pin_remapped[p])
        );
    end

endmodule : rps_top
`default_nettype wire

// File: verilog/rps_pkg.sv
// Constants and types for the remappable output pin select block
package rps_pkg;

    // Geometry
    localparam int FIELD_W = 6;
    localparam int NUM_PAIRS = 5;
    localparam int NUM_PINS = 10;
    localparam int FIRST_PIN = 6;
    localparam int NUM_FUNCS = 64;
    localparam int PIN15_PAIR = 4;

    // Register byte offsets inside the block
    localparam int OFF_W = 8;
    localparam logic [7:0] OFF_SEL_6_7 = 8'h00;
    localparam logic [7:0] OFF_SEL_8_9 = 8'h04;
    localparam logic [7:0] OFF_SEL_10_11 = 8'h08;
    localparam logic [7:0] OFF_SEL_12_13 = 8'h0C;
    localparam logic [7:0] OFF_SEL_14_15 = 8'h10;

    // Field positions and values
    localparam int HI_LSB = 8;
    localparam int HI_MSB = 13;
    localparam int LO_LSB = 0;
    localparam int LO_MSB = 5;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [5:0] FUNC_NONE = 6'h00;

    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    // Pair of function fields held by one register
    typedef struct packed {
        logic [FIELD_W-1:0] hi;
        logic [FIELD_W-1:0] lo;
    } rps_pair_t;

    // Captured address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic hit;
        logic [2:0] idx;
        logic [3:0] strb;
    } rps_aph_t;

endpackage : rps_pkg

// File: verilog/rps_pin_mux.sv
// One remappable pin: picks its peripheral output or falls back to the port
`timescale 1ns/100ps
`default_nettype none
module rps_pin_mux #(
    parameter int FUNCS = 64,
    parameter int SEL_W = 6
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Selection
    input wire logic [SEL_W-1:0] sel,
    // Peripheral outputs
    input wire logic [FUNCS-1:0] periph_data,
    input wire logic [FUNCS-1:0] periph_oe,
    // Ordinary port function
    input wire logic port_data,
    input wire logic port_oe,
    // Pin
    output logic pin_out_ff,
    output logic pin_oe_ff,
    output logic remapped_ff
);

    if (FUNCS > (1 << SEL_W) || FUNCS < 2) begin : g_chk
        $error("rps_pin_mux: FUNCS does not fit SEL_W");
    end

    logic active;
    logic nxt_out;
    logic nxt_oe;

    always_comb begin
        active = (sel != '0) && (int'(sel) < FUNCS);
        if (active) begin
            nxt_out = periph_data[sel];
            nxt_oe = periph_oe[sel];
        end else begin
            nxt_out = port_data;
            nxt_oe = port_oe;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
            remapped_ff <= 1'b0;
        end else begin
            pin_out_ff <= nxt_out;
            pin_oe_ff <= nxt_oe;
            remapped_ff <= active;
        end
    end

endmodule : rps_pin_mux
`default_nettype wire

// File: verif/rps_top_asserts.sv
// Assertions on the ports of the output pin select block
`timescale 1ns/100ps
`default_nettype none
module rps_top_asserts #(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic [9:0] port_data,
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_remapped
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_okay;
        hreadyout && hresp == 2'h0;
    endproperty
    a_okay: assert property (p_okay) else $error("bus not okay");
    property p_top;
        hrdata[15:14] == 2'h0;
    endproperty
    a_top: assert property (p_top) else $error("bits 15:14 set");
    property p_mid;
        hrdata[7:6] == 2'h0;
    endproperty
    a_mid: assert property (p_mid) else $error("bits 7:6 set");
    property p_upper;
        hrdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper half set");
    sequence s_no_remap;
        pin_remapped == 10'h000;
    endsequence
    property p_reset;
        $rose(hresetn) |-> s_no_remap [*2];
    endproperty
    a_reset: assert property (p_reset) else $error("remap after reset");
    property p_port;
        $past(hresetn) |->
            ((pin_out ^ $past(port_data)) & ~pin_remapped) == 10'h000;
    endproperty
    a_port: assert property (p_port) else $error("port not passed");
    property p_change;
        $changed(pin_remapped) && $past(hresetn, 3) |->
            $past(hsel && hready && htrans[1] && hwrite, 3);
    endproperty
    a_change: assert property (p_change) else $error("remap w/o write");
    property p_small;
        SMALL_PACKAGE |-> !pin_remapped[9];
    endproperty
    a_small: assert property (p_small) else $error("pin 15 remapped");
endmodule : rps_top_asserts
bind rps_top rps_top_asserts #(.SMALL_PACKAGE(SMALL_PACKAGE)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .port_data(port_data),
    .pin_out(pin_out), .pin_remapped(pin_remapped)
);
`default_nettype wire

// File: verif/rps_periph_model.sv
// Peripheral and port side feeding the pin select block
`timescale 1ns/100ps
`default_nettype none
module rps_periph_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Peripheral and port outputs
    output logic [63:0] func_ff,
    output logic [63:0] func_oe_ff,
    output logic [9:0] port_ff,
    output logic [9:0] port_oe_ff
);
    // Patterns shift every cycle so a wrong pick shows
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            func_ff <= 64'h0123_4567_89AB_CDEF;
            func_oe_ff <= 64'h5A5A_0F0F_3C3C_9669;
            port_ff <= 10'h2A5;
            port_oe_ff <= 10'h0F3;
        end else begin
            func_ff <= ~{func_ff[62:0], func_ff[63]};
            func_oe_ff <= {func_oe_ff[0], func_oe_ff[63:1]};
            port_ff <= ~{port_ff[8:0], port_ff[9]};
            port_oe_ff <= {port_oe_ff[0], port_oe_ff[9:1]};
        end
    end
endmodule : rps_periph_model
`default_nettype wire

// File: verif/rps_top_tb.sv
// Self-checking bench for the output pin select block
`timescale 1ns/100ps
`default_nettype none
module rps_top_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic [1:0] hresp;
    logic [31:0] hrdata;
    logic [63:0] pd, po, pd_q, po_q;
    logic [9:0] pt, pe, pt_q, pe_q, pin_out, pin_oe, pin_rm;
    logic [5:0] fld [10];
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #20 hclk = ~hclk;
    always @(posedge hclk) begin
        pd_q <= pd;
        po_q <= po;
        pt_q <= pt;
        pe_q <= pe;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    rps_top #(.SMALL_PACKAGE(1'b1)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .periph_data(pd), .periph_oe(po), .port_data(pt), .port_oe(pe),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_remapped(pin_rm));
    rps_periph_model u_per (.hclk(hclk), .hresetn(hresetn), .func_ff(pd),
        .func_oe_ff(po), .port_ff(pt), .port_oe_ff(pe));
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wait_rdy(output logic [31:0] r);
        logic rdy;
        do begin
            @(negedge hclk);
            rdy = hreadyout;
            r = hrdata;
            @(posedge hclk);
        end while (rdy !== 1'b1);
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= rps_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy(r);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(r);
    endtask : bus
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [31:0] a, e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk("hrdata", e, r);
    endtask : rd
    task automatic chk_pins;
        logic [9:0] eo, ee, er;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        for (int i = 0; i < 10; i++) begin
            er[i] = fld[i] != 6'h00;
            eo[i] = er[i] ? pd_q[fld[i]] : pt_q[i];
            ee[i] = er[i] ? po_q[fld[i]] : pe_q[i];
        end
        chk("pin_out", {22'h0, eo}, {22'h0, pin_out});
        chk("pin_oe", {22'h0, ee}, {22'h0, pin_oe});
        chk("pin_remapped", {22'h0, er}, {22'h0, pin_rm});
    endtask : chk_pins
    task automatic t_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        fld = '{default: 6'h00};
        for (int k = 0; k < 6; k++) rd(32'(k * 4), 32'h0000_0000);
        chk_pins();
    endtask : t_reset
    task automatic t_unused;
        for (int k = 0; k < 5; k++) begin
            fld[2 * k] = 6'h3F;
            fld[2 * k + 1] = (k == 4) ? 6'h00 : 6'h3F;
            wr(32'(k * 4), 32'hFFFF_FFFF);
            rd(32'(k * 4), {18'h0, fld[2 * k + 1], 2'h0, 6'h3F});
        end
        chk_pins();
    endtask : t_unused
    task automatic t_route;
        logic [5:0] lo, hi;
        for (int k = 0; k < 5; k++) begin
            lo = 6'(k * 12 + 5);
            hi = (k == 4) ? 6'h00 : 6'(k * 12 + 11);
            fld[2 * k] = lo;
            fld[2 * k + 1] = hi;
            wr(32'(k * 4), {16'hFFFF, 2'h3, 6'(k * 12 + 11), 2'h3, lo});
            rd(32'(k * 4), {18'h0, hi, 2'h0, lo});
        end
        chk_pins();
        chk_pins();
    endtask : t_route
    task automatic t_revert;
        fld[0] = 6'h00;
        fld[1] = 6'h00;
        wr(32'h0000_0000, 32'h0000_0000);
        rd(32'h0000_0000, 32'h0000_0000);
        chk_pins();
    endtask : t_revert
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        t_reset();
        t_unused();
        t_route();
        t_revert();
        t_reset();
        final_report();
    end
endmodule : rps_top_tb
`default_nettype wire
